// ==== code_format.sv ====
// Output code formatter: saturates the raw sample and applies the selected coding.
// Assumes the sample is in LSBs above negative full scale, possibly out of span.
`timescale 1ns/10ps
`include "sar_cfg_defines.svh"
module code_format #(
	parameter int W = 16
) (
	// Raw sample and coding
	input  wire logic signed [W+1:0] sample,
	input  wire logic                binary,
	// Formatted code
	output logic             [W-1:0] code
);
	logic [W-1:0] bin;

	always_comb begin
		if (sample < 0) begin
			bin = `CODE_BIN_BOT;
		end else if (sample > `CODE_MAX) begin
			bin = `CODE_BIN_TOP;
		end else begin
			bin = sample[W-1:0];
		end
		// Twos complement is offset binary with the sign bit flipped
		code = binary ? bin : (bin ^ `CODE_FLIP);
	end

endmodule : code_format

// ==== host_pins_model.sv ====
// Host side of the conversion start pin: issues start pulses on request.
// Assumes pclk and presetn of the block; pulses start low for two cycles.
`timescale 1ns/10ps
module host_pins_model #(
	parameter int GAP = 210
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Request from the bench
	input  wire logic go,
	input  wire logic hurry,
	// Start pin
	output logic      cst_n
);
	logic [7:0] cnt_q;
	logic [1:0] low_q;

	// Holds spacing unless told to hurry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
			low_q <= 2'h0;
			cst_n <= 1'b1;
		end else begin
			if (cnt_q != 8'(GAP))
				cnt_q <= cnt_q + 8'h01;
			if (low_q != 2'h0) begin
				low_q <= low_q - 2'h1;
				if (low_q == 2'h1)
					cst_n <= 1'b1;
			end else if (go && (hurry || cnt_q == 8'(GAP))) begin
				cst_n <= 1'b0;
				low_q <= 2'h2;
				cnt_q <= 8'h00;
			end
		end
	end
endmodule : host_pins_model

// ==== sar_cfg_defines.svh ====
// Offsets, field positions, reset values and timing counts for the converter control block.
// Assumes a 100 MHz pclk and 32-bit APB with byte addresses.
// How it works
// - Both mode pins equal selects normal mode
// - Fast low, low-power high: low-power, 500 kSPS
// - Low-power mode powers down after each conversion
// - Coding is straight binary or twos complement
// - Software coding setting overrides the coding pin
// - Sixteen-bit codes, midscale 0x8000 or 0x0000
// - Overrange saturates to top or bottom code
// - Signed and wide pins pick four input ranges
// - Software range setting overrides both range pins
// - Fast high, low-power low selects warp mode
// - New settings apply at the next acquisition
`ifndef SAR_CFG_DEFINES_SVH
`define SAR_CFG_DEFINES_SVH

`define CFG_OFS       12'h000
`define STAT_OFS      12'h004
`define RES_OFS       12'h008

`define CFG_FAST_BIT  0
`define CFG_LOWP_BIT  1
`define CFG_BIP_BIT   2
`define CFG_WIDE_BIT  3
`define CFG_BIN_BIT   4
`define CFG_RST       5'h10
`define STAT_TF_BIT   1

`define CODE_BIN_TOP  16'hffff
`define CODE_BIN_BOT  16'h0000
`define CODE_FLIP     16'h8000
`define CODE_MAX      18'sh0ffff

`define CLK_NS        10
`define WARP_KSPS     750
`define NORM_KSPS     600
`define LOWP_KSPS     500
// Least start spacing in cycles, rounded up
`define MIN_GAP(k)    ((1000000 + (k) * `CLK_NS - 1) / ((k) * `CLK_NS))
`define CONV_CYCLES   100

`endif

// ==== sar_cfg_pkg.sv ====
// Types shared by the converter control block and its testbench.
// Assumes the defines header is compiled alongside.
package sar_cfg_pkg;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_LOWPWR = 2'b01,
		MODE_WARP   = 2'b10
	} mode_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_CONV = 1'b1
	} conv_st_t;

	typedef struct packed {
		mode_t mode;
		logic  bipolar;
		logic  wide;
		logic  binary;
	} cfg_t;

	typedef struct packed {
		logic convst_n;
		logic fast_mode;
		logic low_power_mode;
		logic signed_range;
		logic wide_range_pin;
		logic output_coding_pin;
		logic sw_config_sel;
	} pin_in_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		conv_st_t    st;
		logic        cnv_prev;
		logic [4:0]  cfg_reg;
		cfg_t        act;
		logic [7:0]  gap;
		logic [7:0]  cnt;
		logic        too_fast;
		logic        pd;
		logic [15:0] result;
		apb_rsp_t    rsp;
	} state_t;

endpackage : sar_cfg_pkg

// ==== sar_mode_ctrl.sv ====
// Mode, range and coding control for a 16-bit SAR converter, with an APB register port.
// Assumes pins and the raw sample are synchronous to pclk; the analog core follows cfg_o.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
`include "sar_cfg_defines.svh"
module sar_mode_ctrl
	import sar_cfg_pkg::*;
#(
	parameter int CONV_CYCLES = `CONV_CYCLES
) (
	// Clock, reset, enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB
	input  wire sar_cfg_pkg::apb_req_t apb_req,
	output sar_cfg_pkg::apb_rsp_t  apb_rsp,
	// Configuration pins and start
	input  wire sar_cfg_pkg::pin_in_t pins,
	// Analog core
	input  wire logic signed [17:0] sample_val,
	output sar_cfg_pkg::cfg_t      cfg_o,
	output logic                   busy_o,
	output logic                   conv_pd_o,
	output logic [15:0]            result_o
);
	import sar_cfg_pkg::*;

	localparam logic [8:0] GAP_WARP = 9'(`MIN_GAP(`WARP_KSPS));
	localparam logic [8:0] GAP_NORM = 9'(`MIN_GAP(`NORM_KSPS));
	localparam logic [8:0] GAP_LOWP = 9'(`MIN_GAP(`LOWP_KSPS));
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
	localparam cfg_t CFG_RESET = cfg_t'{mode: MODE_NORMAL, bipolar: 1'b0,
		wide: 1'b0, binary: 1'b1};
	localparam state_t STATE_RST = state_t'{st: ST_IDLE, cnv_prev: 1'b1,
		cfg_reg: `CFG_RST, act: CFG_RESET, gap: 8'hff, cnt: 8'h00,
		too_fast: 1'b0, pd: 1'b0, result: 16'h0000,
		rsp: apb_rsp_t'{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000}};

	state_t      s_q;
	state_t      s_d;
	cfg_t        sel;
	logic        start;
	logic        access;
	logic        mapped;
	logic [8:0]  min_gap;
	logic [15:0] code;

	function automatic mode_t decode_mode(input logic fast, input logic lowp);
		if (fast == lowp) begin
			return MODE_NORMAL;
		end else if (fast) begin
			return MODE_WARP;
		end else begin
			return MODE_LOWPWR;
		end
	endfunction : decode_mode

	code_format #(
		.W (16)
	) u_fmt (
		.sample (sample_val),
		.binary (s_q.act.binary),
		.code   (code)
	);

	// Register settings replace every configuration pin in software mode
	always_comb begin
		if (pins.sw_config_sel) begin
			sel.mode    = decode_mode(s_q.cfg_reg[`CFG_FAST_BIT], s_q.cfg_reg[`CFG_LOWP_BIT]);
			sel.bipolar = s_q.cfg_reg[`CFG_BIP_BIT];
			sel.wide    = s_q.cfg_reg[`CFG_WIDE_BIT];
			sel.binary  = s_q.cfg_reg[`CFG_BIN_BIT];
		end else begin
			sel.mode    = decode_mode(pins.fast_mode, pins.low_power_mode);
			sel.bipolar = pins.signed_range;
			sel.wide    = pins.wide_range_pin;
			sel.binary  = pins.output_coding_pin;
		end
	end

	always_comb begin
		unique case (sel.mode)
			MODE_WARP:   min_gap = GAP_WARP;
			MODE_LOWPWR: min_gap = GAP_LOWP;
			default:     min_gap = GAP_NORM;
		endcase
	end

	assign start  = s_q.cnv_prev & ~pins.convst_n;
	assign access = apb_req.psel & apb_req.penable & s_q.rsp.pready;
	assign mapped = (apb_req.paddr == `CFG_OFS) || (apb_req.paddr == `STAT_OFS) ||
		(apb_req.paddr == `RES_OFS);

	always_comb begin
		s_d          = s_q;
		s_d.cnv_prev = pins.convst_n;
		if (s_q.gap != 8'hff) begin
			s_d.gap = s_q.gap + 8'd1;
		end

		// APB: answer is prepared in the setup cycle so outputs stay registered
		if (apb_req.psel && !apb_req.penable) begin
			s_d.rsp.pready  = 1'b1;
			s_d.rsp.pslverr = !mapped;
			unique case (apb_req.paddr)
				`CFG_OFS:  s_d.rsp.prdata = {27'h0, s_q.cfg_reg};
				`STAT_OFS: s_d.rsp.prdata = {23'h0, pins.sw_config_sel, s_q.act,
					s_q.pd, s_q.too_fast, s_q.st == ST_CONV};
				`RES_OFS:  s_d.rsp.prdata = {16'h0, s_q.result};
				default:   s_d.rsp.prdata = 32'h0000_0000;
			endcase
		end else begin
			s_d.rsp.pready  = 1'b0;
			s_d.rsp.pslverr = 1'b0;
		end
		if (access && apb_req.pwrite) begin
			if (apb_req.paddr == `CFG_OFS) begin
				s_d.cfg_reg = apb_req.pwdata[4:0];
			end
			if (apb_req.paddr == `STAT_OFS && apb_req.pwdata[`STAT_TF_BIT]) begin
				s_d.too_fast = 1'b0;
			end
		end

		// Settings latch at the start edge; a start while converting is ignored
		unique case (s_q.st)
			ST_IDLE: begin
				if (start) begin
					s_d.st  = ST_CONV;
					s_d.act = sel;
					s_d.cnt = 8'h00;
					s_d.pd  = 1'b0;
					s_d.gap = 8'h00;
					// Set after the clear so a same-cycle event is kept
					if ({1'b0, s_q.gap} + 9'd1 < min_gap) begin
						s_d.too_fast = 1'b1;
					end
				end
			end
			ST_CONV: begin
				if (s_q.cnt == CONV_LAST) begin
					s_d.st     = ST_IDLE;
					s_d.result = code;
					s_d.pd     = (s_q.act.mode == MODE_LOWPWR);
				end else begin
					s_d.cnt = s_q.cnt + 8'd1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= STATE_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign apb_rsp   = s_q.rsp;
	assign cfg_o     = s_q.act;
	assign busy_o    = (s_q.st == ST_CONV);
	assign conv_pd_o = s_q.pd;
	assign result_o  = s_q.result;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_take;
		ce && start && s_q.st == ST_IDLE;
	endsequence

	sequence s_end;
		ce && s_q.st == ST_CONV && s_q.cnt == CONV_LAST;
	endsequence

	a_normal_decode: assert property (
		s_take and (!pins.sw_config_sel && pins.fast_mode == pins.low_power_mode)
		|=> s_q.act.mode == MODE_NORMAL && busy_o)
		else $error("normal mode not taken");

	a_warp_decode: assert property (
		s_take and (!pins.sw_config_sel && pins.fast_mode && !pins.low_power_mode)
		|=> s_q.act.mode == MODE_WARP)
		else $error("warp mode not taken");

	a_lowp_rate_flag: assert property (
		s_take and (sel.mode == MODE_LOWPWR && s_q.gap < 8'd199)
		|=> s_q.too_fast)
		else $error("fast start in low-power mode not flagged");

	// A back-to-back start may legally clear power-down one cycle later
	a_lowp_powerdown: assert property (
		s_end and (s_q.act.mode == MODE_LOWPWR)
		|=> conv_pd_o && !busy_o ##1 (conv_pd_o || busy_o))
		else $error("low-power mode did not power down after conversion");

	a_ce_freeze: assert property (
		!ce |=> $stable(s_q))
		else $error("state moved while clock enable was low");

	a_pin_source: assert property (
		s_take and !pins.sw_config_sel |=> s_q.act.binary == $past(pins.output_coding_pin)
		&& s_q.act.bipolar == $past(pins.signed_range)
		&& s_q.act.wide == $past(pins.wide_range_pin))
		else $error("pin configuration not applied");

	a_reg_override: assert property (
		s_take and pins.sw_config_sel |=> s_q.act.binary == $past(s_q.cfg_reg[`CFG_BIN_BIT])
		&& s_q.act.bipolar == $past(s_q.cfg_reg[`CFG_BIP_BIT])
		&& s_q.act.wide == $past(s_q.cfg_reg[`CFG_WIDE_BIT]))
		else $error("register configuration not applied");

	a_mid_code: assert property (
		s_end and (sample_val == 18'sh08000)
		|=> result_o == (s_q.act.binary ? 16'h8000 : 16'h0000))
		else $error("midscale code wrong");

	a_sat_top: assert property (
		s_end and (sample_val > 18'sh0ffff)
		|=> result_o == (s_q.act.binary ? 16'hffff : 16'h7fff))
		else $error("overrange not saturated to top code");

	a_sat_bottom: assert property (
		s_end and (sample_val < 0)
		|=> result_o == (s_q.act.binary ? 16'h0000 : 16'h8000))
		else $error("underrange not saturated to bottom code");

endmodule : sar_mode_ctrl

// ==== sar_mode_ctrl_tb.sv ====
// Self-checking bench for the converter control block.
// Assumes the APB slave answers before the bench timeout; conversions shortened to 5 cycles.
`timescale 1ns/10ps
module sar_mode_ctrl_tb;
	import sar_cfg_pkg::*;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	apb_req_t           req = '0;
	apb_rsp_t           rsp;
	pin_in_t            pv = '0;
	pin_in_t            pins_w;
	logic signed [17:0] smp = '0;
	cfg_t               cfg;
	logic               busy, pd, go = 1'b0, hurry = 1'b0, cst_n, ce = 1'b1;
	logic        [15:0] res;
	logic        [31:0] r;
	logic               e;
	int                 bad_count = 0, checks = 0, cyc = 0;
	int                 sv[5] = '{-5, 0, 32768, 65535, 70000};

	always #5 pclk = ~pclk;
	always_comb begin
		pins_w = pv;
		pins_w.convst_n = cst_n;
	end
	host_pins_model hm (.pclk(pclk), .presetn(presetn), .go(go), .hurry(hurry), .cst_n(cst_n));
	sar_mode_ctrl #(.CONV_CYCLES(5)) uut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.apb_req(req), .apb_rsp(rsp), .pins(pins_w), .sample_val(smp), .cfg_o(cfg),
		.busy_o(busy), .conv_pd_o(pd), .result_o(res));

	task stop_test();
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task conv(input int s);
		@(posedge pclk);
		smp <= 18'(s);
		go <= 1'b1;
		while (busy !== 1'b1) @(posedge pclk);
		go <= 1'b0;
		while (busy !== 1'b0) @(posedge pclk);
	endtask : conv

	function automatic logic [15:0] xc(int s, logic b);
		logic [15:0] v;
		v = (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : 16'(s);
		return b ? v : v ^ 16'h8000;
	endfunction : xc

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk("cfg_o", 32'h1, 32'(cfg));
		apb(1'b0, 12'h000, '0);
		chk("cfg reg", 32'h10, r);
		apb(1'b0, 12'h00c, '0);
		chk("unmapped", 32'h1, {31'h0, e});
		for (int i = 0; i < 4; i++) begin
			pv.fast_mode <= i[1];
			pv.low_power_mode <= i[0];
			conv(100);
			chk("mode", (i == 1) ? 32'(MODE_LOWPWR) : (i == 2) ? 32'(MODE_WARP) : 32'(MODE_NORMAL), 32'(cfg.mode));
			chk("pd", 32'(i == 1), 32'(pd));
			pv.signed_range <= i[1];
			pv.wide_range_pin <= i[0];
			conv(7);
			chk("range", 32'(i), {30'h0, cfg.bipolar, cfg.wide});
		end
		for (int b = 0; b < 2; b++)
			for (int k = 0; k < 5; k++) begin
				pv.output_coding_pin <= b[0];
				conv(sv[k]);
				chk("code", 32'(xc(sv[k], b[0])), 32'(res));
			end
		apb(1'b1, 12'h000, 32'h0d);
		apb(1'b0, 12'h000, '0);
		chk("cfg rw", 32'h0d, r);
		pv <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		conv(0);
		chk("sw cfg", 32'h16, 32'(cfg));
		chk("sw code", 32'h8000, 32'(res));
		apb(1'b0, 12'h004, '0);
		chk("stat", 32'h1b0, r);
		// Register low-power mode, twos complement, so fast starts hit the rate flag
		apb(1'b1, 12'h000, 32'h02);
		hurry <= 1'b1;
		conv(1);
		conv(2);
		apb(1'b0, 12'h004, '0);
		chk("too fast", 32'h1, 32'(r[1]));
		chk("stat pd", 32'h1, 32'(r[2]));
		apb(1'b1, 12'h004, 32'h2);
		apb(1'b0, 12'h004, '0);
		chk("flag clear", 32'h0, 32'(r[1]));
		apb(1'b0, 12'h008, '0);
		chk("res reg", 32'h8002, r);
		// Freeze mid-conversion: busy must outlast the 5-cycle conversion
		go <= 1'b1;
		while (busy !== 1'b1) @(posedge pclk);
		go <= 1'b0;
		ce <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("ce freeze", 32'h1, 32'(busy));
		ce <= 1'b1;
		while (busy !== 1'b0) @(posedge pclk);
		stop_test();
	end
endmodule : sar_mode_ctrl_tb
